// >>> design/tc_timer.sv
// 16-bit up/down timer with input capture on an 8-bit bus
// Notes on behaviour
// - counter seen as two bytes, high via latch
// - low read loads latch; low write commits
// - latch holds its value between accesses
// - software keeps two-byte accesses uninterrupted
// - write high first; read low first
// - clock select picks tick; zero stops
// - counter accessible whether running or not
// - cpu write beats count and clear
// - tick clears, counts up or down; top/bottom
// - four-bit mode split over both controls
// - overflow flag set per mode, interrupt source
// - trigger edge copies counter, sets capture flag
// - enabled flag interrupts; ack or one clears
// - capture low read loads latch with high
// - capture writable only in capture-top modes
// - comparator select switches trigger source
// - source switch may capture; clear flag after
// - triggers share external clock sync and edge
// - filter changes after four agreeing samples
// - filter enable bit adds four clocks
// - capture off in capture-top modes
// - each capture overwrites the capture value
// - driving the pin by port output captures
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "tc_params.svh"
module tc_timer
  import tc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  tc_link_if.dev io,
  input wire logic [3:0] presc_tick,
  input wire logic external_clock_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  output logic at_top,
  output logic at_bottom
);
  tc_byte_type timer_control_a;
  tc_byte_type timer_control_b;
  tc_byte_type comparator_control_register;
  tc_byte_type temp_high;
  tc_byte_type irq_mask;
  tc_word_type timer_count;
  tc_word_type capture_value;
  tc_word_type top_value;
  tc_byte_type next_rdata;
  logic count_up;
  logic counter_overflow_flag;
  logic capture_flag;
  logic [3:0] waveform_mode_select;
  logic [2:0] clock_source_select;
  logic dual_slope;
  logic capture_top;
  logic clear_on_top;
  logic ext_lvl;
  logic ext_prev;
  logic cap_lvl;
  logic cap_prev;
  logic timer_tick;
  logic cnt_write;
  logic ovf_event;
  logic capture_event;
  logic trigger_src;

  initial begin
    if (CNT_W != 16) $error("tc_timer: CNT_W must be 16");
  end

  // mode and clock fields gathered from both control bytes
  assign waveform_mode_select = {timer_control_b[`TC_WGM_HI_LSB +: 2],
    timer_control_a[`TC_WGM_LO_LSB +: 2]};
  assign clock_source_select = timer_control_b[`TC_CS_LSB +: 3];
  assign cnt_write = io.wr && (io.addr == `TC_A_CNT_L);

  // top value and counting style per waveform mode
  always_comb begin
    top_value = `TC_MAX;
    dual_slope = 1'b0;
    capture_top = 1'b0;
    clear_on_top = 1'b1;
    case (waveform_mode_select)
      4'h1: begin
        top_value = `TC_TOP_8;
        dual_slope = 1'b1;
      end
      4'h2: begin
        top_value = `TC_TOP_9;
        dual_slope = 1'b1;
      end
      4'h3: begin
        top_value = `TC_TOP_10;
        dual_slope = 1'b1;
      end
      4'h5: top_value = `TC_TOP_8;
      4'h6: top_value = `TC_TOP_9;
      4'h7: top_value = `TC_TOP_10;
      4'h8, 4'hA: begin
        top_value = capture_value;
        dual_slope = 1'b1;
        capture_top = 1'b1;
      end
      4'hC: begin
        top_value = capture_value;
        capture_top = 1'b1;
        clear_on_top = 1'b0;
      end
      4'hE: begin
        top_value = capture_value;
        capture_top = 1'b1;
      end
      default: top_value = `TC_MAX;
    endcase
  end

  // external clock pin through the shared synchroniser
  tc_filt #(.LEN(`TC_FILT_LEN)) u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .din(external_clock_pin),
    .filt_en(1'b0),
    .dout(ext_lvl)
  );

  // trigger source: pin or comparator, same sync and edge logic
  assign trigger_src = comparator_control_register[`TC_COMPARATOR_CAPTURE_SELECT_BIT] ?
    comparator_output : capture_input_pin;
  tc_filt #(.LEN(`TC_FILT_LEN)) u_cap (
    .clk(clk),
    .rst_n(rst_n),
    .din(trigger_src),
    .filt_en(timer_control_b[`TC_FILT_BIT]),
    .dout(cap_lvl)
  );

  // edge detector history for both pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      ext_prev <= ext_lvl;
      cap_prev <= cap_lvl;
    end
  end

  // tick selection; select zero leaves the counter stopped
  always_comb begin
    case (clock_source_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = 1'b1;
      3'h2: timer_tick = presc_tick[0];
      3'h3: timer_tick = presc_tick[1];
      3'h4: timer_tick = presc_tick[2];
      3'h5: timer_tick = presc_tick[3];
      3'h6: timer_tick = ext_prev & ~ext_lvl;
      3'h7: timer_tick = ext_lvl & ~ext_prev;
      default: timer_tick = 1'b0;
    endcase
  end

  // the pin level edge chosen by the edge bit counts, including a source switch
  // or the pin being driven by its own port output
  assign capture_event = ~capture_top
    & (timer_control_b[`TC_EDGE_BIT] ? (cap_lvl & ~cap_prev)
    : (cap_prev & ~cap_lvl));

  assign at_top = (timer_count == top_value);
  assign at_bottom = (timer_count == `TC_RST_WORD);
  assign ovf_event = timer_tick & ~cnt_write & (dual_slope ?
    (~count_up & at_bottom) : (clear_on_top ? at_top :
    (timer_count == `TC_MAX)));

  // counter: cpu write first, then count, clear or turn
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= `TC_RST_WORD;
      count_up <= 1'b1;
    end else if (cnt_write) begin
      timer_count <= {temp_high, io.wdata};
    end else if (timer_tick) begin
      if (dual_slope) begin
        if (count_up && at_top) begin
          count_up <= 1'b0;
          timer_count <= timer_count - 16'h0001;
        end else if (!count_up && at_bottom) begin
          count_up <= 1'b1;
          timer_count <= timer_count + 16'h0001;
        end else if (count_up) begin
          timer_count <= timer_count + 16'h0001;
        end else begin
          timer_count <= timer_count - 16'h0001;
        end
      end else begin
        count_up <= 1'b1;
        if (at_top) timer_count <= `TC_RST_WORD;
        else timer_count <= timer_count + 16'h0001;
      end
    end
  end

  // shared high-byte latch: high writes load it, low reads fill it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) temp_high <= `TC_RST_BYTE;
    else if (io.wr && (io.addr == `TC_A_CNT_H ||
      io.addr == `TC_A_CAP_H)) temp_high <= io.wdata;
    else if (io.rd && io.addr == `TC_A_CNT_L)
      temp_high <= timer_count[15:8];
    else if (io.rd && io.addr == `TC_A_CAP_L)
      temp_high <= capture_value[15:8];
  end // otherwise held

  // capture value: trigger copies counter, write only as top
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) capture_value <= `TC_RST_WORD;
    else if (capture_event) capture_value <= timer_count;
    else if (io.wr && io.addr == `TC_A_CAP_L && capture_top)
      capture_value <= {temp_high, io.wdata};
  end

  // sticky flags; a new event beats ack or write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_overflow_flag <= 1'b0;
      capture_flag <= 1'b0;
    end else begin
      counter_overflow_flag <= ovf_event | (counter_overflow_flag &
        ~(io.ovf_ack | (io.wr && io.addr == `TC_A_FLAGS &&
        io.wdata[`TC_OVF_BIT])));
      capture_flag <= capture_event | (capture_flag &
        ~(io.cap_ack | (io.wr && io.addr == `TC_A_FLAGS &&
        io.wdata[`TC_CAP_BIT])));
    end
  end

  // plain control bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_a <= `TC_RST_BYTE;
      timer_control_b <= `TC_RST_BYTE;
      irq_mask <= `TC_RST_BYTE;
      comparator_control_register <= `TC_RST_BYTE;
    end else if (io.wr) begin
      case (io.addr)
        `TC_A_CTRL_A: timer_control_a <= io.wdata;
        `TC_A_CTRL_B: timer_control_b <= io.wdata;
        `TC_A_MASK: irq_mask <= io.wdata;
        `TC_A_COMP: comparator_control_register <= io.wdata;
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  assign io.ovf_irq = counter_overflow_flag & irq_mask[`TC_OVF_BIT];
  assign io.cap_irq = capture_flag & irq_mask[`TC_CAP_BIT];

  // read mux; high locations return the latch
  always_comb begin
    next_rdata = `TC_RST_BYTE;
    case (io.addr)
      `TC_A_CTRL_A: next_rdata = timer_control_a;
      `TC_A_CTRL_B: next_rdata = timer_control_b;
      `TC_A_CNT_L: next_rdata = timer_count[7:0];
      `TC_A_CNT_H: next_rdata = temp_high;
      `TC_A_CAP_L: next_rdata = capture_value[7:0];
      `TC_A_CAP_H: next_rdata = temp_high;
      `TC_A_FLAGS: begin
        next_rdata[`TC_OVF_BIT] = counter_overflow_flag;
        next_rdata[`TC_CAP_BIT] = capture_flag;
      end
      `TC_A_MASK: next_rdata = irq_mask;
      `TC_A_COMP: next_rdata = comparator_control_register;
      default: next_rdata = `TC_RST_BYTE;
    endcase
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) io.rdata <= `TC_RST_BYTE;
    else if (io.rd) io.rdata <= next_rdata;
  end
endmodule

// >>> design/tc_params.svh
// register map, field positions, reset values and fixed tops
`ifndef TC_PARAMS_SVH
`define TC_PARAMS_SVH
// device byte locations on the 8-bit bus
`define TC_A_CTRL_A 4'h0
`define TC_A_CTRL_B 4'h1
`define TC_A_CNT_L 4'h2
`define TC_A_CNT_H 4'h3
`define TC_A_CAP_L 4'h4
`define TC_A_CAP_H 4'h5
`define TC_A_FLAGS 4'h6
`define TC_A_MASK 4'h7
`define TC_A_COMP 4'h8
// field positions
`define TC_WGM_LO_LSB 0
`define TC_CS_LSB 0
`define TC_WGM_HI_LSB 3
`define TC_EDGE_BIT 6
`define TC_FILT_BIT 7
`define TC_OVF_BIT 0
`define TC_CAP_BIT 5
`define TC_COMPARATOR_CAPTURE_SELECT_BIT 2
// reset values
`define TC_RST_BYTE 8'h00
`define TC_RST_WORD 16'h0000
// fixed tops and extremes
`define TC_TOP_8 16'h00FF
`define TC_TOP_9 16'h01FF
`define TC_TOP_10 16'h03FF
`define TC_MAX 16'hFFFF
`define TC_FILT_LEN 4
// host APB offsets and fields
`define TC_P_REQ 12'h000
`define TC_P_STAT 12'h004
`define TC_P_ACK 12'h008
`define TC_RQ_WDATA_LSB 8
`define TC_RQ_WR_BIT 24
`define TC_RQ_PAIR_BIT 25
`define TC_ST_BUSY_BIT 0
`define TC_ST_OVF_BIT 1
`define TC_ST_CAP_BIT 2
`define TC_ST_DATA_LSB 16
`endif

// >>> design/tc_pkg.sv
// shared types of the timer block
package tc_pkg;
  typedef enum logic [1:0] {
    TC_IDLE, TC_FIRST, TC_SECOND, TC_DONE
  } tc_host_state_type;
  typedef logic [7:0] tc_byte_type;
  typedef logic [15:0] tc_word_type;
endpackage

// >>> design/tc_link_if.sv
// byte bus and interrupt lines between cpu side and timer
`timescale 1ns/1ps
interface tc_link_if;
  import tc_pkg::*;
  logic [3:0] addr;
  logic wr;
  logic rd;
  tc_byte_type wdata;
  tc_byte_type rdata;
  logic ovf_irq;
  logic cap_irq;
  logic ovf_ack;
  logic cap_ack;
  modport dev (input addr, wr, rd, wdata, ovf_ack, cap_ack,
    output rdata, ovf_irq, cap_irq);
  modport cpu (output addr, wr, rd, wdata, ovf_ack, cap_ack,
    input rdata, ovf_irq, cap_irq);
endinterface

// >>> design/tc_filt.sv
// pin synchroniser with optional agreeing-samples noise filter
`timescale 1ns/1ps
`include "tc_params.svh"
module tc_filt #(
  parameter int LEN = `TC_FILT_LEN
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  input wire logic filt_en,
  output logic dout
);
  logic s1;
  logic s2;
  logic [LEN-1:0] hist;

  initial begin
    if (LEN < 2) $error("tc_filt: LEN must be at least 2");
  end

  // two-stage synchroniser; s1 feeds only s2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
    end
  end

  // sample history of the synchronised level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hist <= '0;
    else hist <= {hist[LEN-2:0], s2};
  end

  // output follows only when all samples agree, or directly if bypassed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dout <= 1'b0;
    else if (!filt_en) dout <= s2;
    else if (&hist) dout <= 1'b1;
    else if (~|hist) dout <= 1'b0;
  end
endmodule

// >>> design/tc_cpu.sv
// cpu-side end: APB command registers driving the byte bus
`timescale 1ns/1ps
`include "tc_params.svh"
module tc_cpu
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  tc_link_if.cpu io,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  tc_host_state_type state;
  logic [3:0] req_addr;
  tc_word_type req_data;
  logic req_wr;
  logic req_pair;
  tc_word_type rd_data;
  logic acc;
  logic go;
  logic mapped;

  assign acc = psel & penable;
  assign mapped = (paddr == `TC_P_REQ) || (paddr == `TC_P_STAT) ||
    (paddr == `TC_P_ACK);
  assign go = acc & pwrite & (paddr == `TC_P_REQ) & (state == TC_IDLE);
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // request capture and two-byte sequencing, held atomic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TC_IDLE;
      req_addr <= 4'h0;
      req_data <= `TC_RST_WORD;
      req_wr <= 1'b0;
      req_pair <= 1'b0;
    end else begin
      case (state)
        TC_IDLE: if (go) begin
          req_addr <= pwdata[3:0];
          req_data <= pwdata[`TC_RQ_WDATA_LSB +: 16];
          req_wr <= pwdata[`TC_RQ_WR_BIT];
          req_pair <= pwdata[`TC_RQ_PAIR_BIT];
          state <= TC_FIRST;
        end
        TC_FIRST: state <= req_pair ? TC_SECOND : TC_DONE;
        TC_SECOND: state <= TC_DONE;
        TC_DONE: state <= TC_IDLE;
        default: state <= TC_IDLE;
      endcase
    end
  end

  // byte strobes: pair writes high then low, pair reads low then high
  always_comb begin
    io.wr = 1'b0;
    io.rd = 1'b0;
    io.addr = req_addr;
    io.wdata = req_data[7:0];
    if (state == TC_FIRST || state == TC_SECOND) begin
      io.wr = req_wr;
      io.rd = ~req_wr;
      if (req_pair && (req_wr == (state == TC_FIRST))) begin
        io.addr = req_addr + 4'h1;
        io.wdata = req_data[15:8];
      end
    end
  end

  // gather returned bytes, low byte first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rd_data <= `TC_RST_WORD;
    else if (!req_wr && state == TC_SECOND) rd_data[7:0] <= io.rdata;
    else if (!req_wr && state == TC_DONE) begin
      if (req_pair) rd_data[15:8] <= io.rdata;
      else rd_data <= {8'h00, io.rdata};
    end
  end

  // interrupt-taken acknowledges, one-cycle pulses
  assign io.ovf_ack = acc & pwrite & (paddr == `TC_P_ACK) &
    pwdata[`TC_ST_OVF_BIT];
  assign io.cap_ack = acc & pwrite & (paddr == `TC_P_ACK) &
    pwdata[`TC_ST_CAP_BIT];

  // status readback
  always_comb begin
    prdata = 32'h00000000;
    if (paddr == `TC_P_STAT) begin
      prdata[`TC_ST_BUSY_BIT] = (state != TC_IDLE);
      prdata[`TC_ST_OVF_BIT] = io.ovf_irq;
      prdata[`TC_ST_CAP_BIT] = io.cap_irq;
      prdata[`TC_ST_DATA_LSB +: 16] = rd_data;
    end
  end
endmodule

// >>> verification/tc_link_properties.sv
// link-side checks of the timer byte bus and interrupt lines
`timescale 1ns/1ps
`include "tc_params.svh"
module tc_link_properties
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire tc_byte_type wdata,
  input wire tc_byte_type rdata,
  input wire logic ovf_irq,
  input wire logic cap_irq,
  input wire logic ovf_ack,
  input wire logic cap_ack
);
  logic temp_known;
  tc_byte_type temp_val;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shared high byte, known only after a high-location write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_known <= 1'b0;
      temp_val <= 8'h00;
    end else if (wr && (addr == `TC_A_CNT_H || addr == `TC_A_CAP_H)) begin
      temp_known <= 1'b1;
      temp_val <= wdata;
    end else if (rd && (addr == `TC_A_CNT_L || addr == `TC_A_CAP_L)) begin
      temp_known <= 1'b0;
    end
  end
  property p_high_latch;
    rd && (addr == `TC_A_CNT_H || addr == `TC_A_CAP_H) && temp_known
      |=> rdata == $past(temp_val);
  endproperty
  a_high_latch: assert property (p_high_latch)
    else $error("high read");
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("rdata moved");
  property p_write_order;
    wr && addr == `TC_A_CNT_H |=> wr && addr == `TC_A_CNT_L;
  endproperty
  a_write_order: assert property (p_write_order)
    else $error("wr order");
  property p_read_order;
    rd && (addr == `TC_A_CNT_L || addr == `TC_A_CAP_L)
      |=> rd && addr == $past(addr) + 4'h1;
  endproperty
  a_read_order: assert property (p_read_order)
    else $error("rd order");
  property p_mask_cap;
    wr && addr == `TC_A_MASK && !wdata[`TC_CAP_BIT] |=> !cap_irq;
  endproperty
  a_mask_cap: assert property (p_mask_cap)
    else $error("cap mask");
  property p_mask_ovf;
    wr && addr == `TC_A_MASK && !wdata[`TC_OVF_BIT] |=> !ovf_irq;
  endproperty
  a_mask_ovf: assert property (p_mask_ovf)
    else $error("ovf mask");
  property p_cap_ack;
    cap_ack |=> !cap_irq;
  endproperty
  a_cap_ack: assert property (p_cap_ack)
    else $error("cap ack");
  property p_ovf_ack;
    ovf_ack |=> !ovf_irq;
  endproperty
  a_ovf_ack: assert property (p_ovf_ack)
    else $error("ovf ack");
  property p_cap_w1c;
    wr && addr == `TC_A_FLAGS && wdata[`TC_CAP_BIT] |=> !cap_irq;
  endproperty
  a_cap_w1c: assert property (p_cap_w1c)
    else $error("cap clear");
  property p_flag_read;
    rd && addr == `TC_A_FLAGS && cap_irq |=> rdata[`TC_CAP_BIT];
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read");
  c_cap: cover property ($rose(cap_irq));
  c_ovf: cover property ($rose(ovf_irq));
  c_w1c: cover property (wr && addr == `TC_A_FLAGS);
endmodule

// >>> verification/test_timer16_counter_input_capture.sv
// self-checking bench: cpu end and timer end joined by the byte link
`timescale 1ns/1ps
`include "tc_params.svh"
module test_timer16_counter_input_capture;
  import tc_pkg::*;
  typedef struct {
    logic [3:0] a;
    logic [15:0] d;
    logic w;
    logic p;
    logic [15:0] e;
  } tc_row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] presc_tick = 4'h0;
  logic ext_pin = 1'b0;
  logic cap_pin = 1'b0;
  logic comp_out = 1'b0;
  logic at_top;
  logic at_bottom;
  logic [31:0] stat;
  logic err;
  logic [15:0] got;
  int failures = 0;
  int n_tests = 0;
  // plain accesses with the timer stopped
  tc_row_type rows [7] = '{
    '{4'h1, 16'h0000, 1'b1, 1'b0, 16'h0000},
    '{4'h2, 16'h01FF, 1'b1, 1'b1, 16'h0000},
    '{4'h2, 16'h0000, 1'b0, 1'b1, 16'h01FF},
    '{4'h2, 16'h3434, 1'b1, 1'b0, 16'h0000},
    '{4'h2, 16'h0000, 1'b0, 1'b1, 16'h0134},
    '{4'h7, 16'h2121, 1'b1, 1'b0, 16'h0000},
    '{4'h7, 16'h0000, 1'b0, 1'b0, 16'h0021}};
  tc_link_if link ();
  tc_timer tc_timer_inst (.clk(clk), .rst_n(rst_n), .io(link),
    .presc_tick(presc_tick), .external_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .comparator_output(comp_out),
    .at_top(at_top), .at_bottom(at_bottom));
  tc_cpu tc_cpu_inst (.clk(clk), .rst_n(rst_n), .io(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  tc_link_properties tc_link_properties_inst (.clk(clk), .rst_n(rst_n),
    .addr(link.addr), .wr(link.wr), .rd(link.rd), .wdata(link.wdata),
    .rdata(link.rdata), .ovf_irq(link.ovf_irq), .cap_irq(link.cap_irq),
    .ovf_ack(link.ovf_ack), .cap_ack(link.cap_ack));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // pready is tied high in tc_cpu, so this wait ends at the first edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    stat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // byte or pair order, then poll status until the link is idle
  task automatic req(input logic [3:0] a, input logic [15:0] d,
    input logic w, input logic p);
    apb(`TC_P_REQ, 1'b1, {6'h00, p, w, d, 4'h0, a});
    do begin
      apb(`TC_P_STAT, 1'b0, 32'h00000000);
    end while (stat[`TC_ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic stat_bit(input int i, input logic e, input string what);
    apb(`TC_P_STAT, 1'b0, 32'h00000000);
    chk({15'h0000, stat[i]}, {15'h0000, e}, what);
  endtask
  // move the pin (sel 0) or the comparator (sel 1), then let it settle
  task automatic trig(input logic sel, input logic v);
    @(posedge clk);
    if (sel) begin
      comp_out <= v;
    end else begin
      cap_pin <= v;
    end
    repeat (12) @(posedge clk);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      presc_tick <= 4'h1;
      @(posedge clk);
      presc_tick <= 4'h0;
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog well beyond the expected several hundred cycles
  initial begin
    #500000;
    failures++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0000, "count after reset");
    chk({15'h0000, at_bottom}, 16'h0001, "bottom");
    done("reset");
    foreach (rows[i]) begin
      req(rows[i].a, rows[i].d, rows[i].w, rows[i].p);
      got = rows[i].p ? stat[31:16] : {8'h00, stat[23:16]};
      if (!rows[i].w) chk(got, rows[i].e, "row");
    end
    apb(12'h00C, 1'b0, 32'h00000000);
    chk({15'h0000, err}, 16'h0001, "unmapped");
    done("table");
    tick(3);
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0134, "stopped count");
    req(4'h2, 16'hFFFE, 1'b1, 1'b1);
    req(4'h1, 16'h0202, 1'b1, 1'b0);
    tick(2);
    req(4'h1, 16'h0000, 1'b1, 1'b0);
    stat_bit(1, 1'b1, "overflow");
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0000, "wrapped count");
    apb(`TC_P_ACK, 1'b1, 32'h00000002);
    stat_bit(1, 1'b0, "overflow taken");
    // dual slope with fixed top 0x00FF: turn at top, overflow at bottom
    req(4'h0, 16'h0101, 1'b1, 1'b0);
    req(4'h1, 16'h0202, 1'b1, 1'b0);
    req(4'h2, 16'h00FF, 1'b1, 1'b1);
    tick(2);
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h00FD, "turn at top");
    req(4'h2, 16'h0001, 1'b1, 1'b1);
    tick(2);
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0001, "turn at bottom");
    chk({15'h0000, stat[1]}, 16'h0001, "bottom overflow");
    req(4'h1, 16'h0000, 1'b1, 1'b0);
    req(4'h0, 16'h0000, 1'b1, 1'b0);
    apb(`TC_P_ACK, 1'b1, 32'h00000002);
    stat_bit(1, 1'b0, "dual overflow taken");
    // external pin as tick source, rising edges counted
    req(4'h2, 16'h0000, 1'b1, 1'b1);
    req(4'h1, 16'h0707, 1'b1, 1'b0);
    repeat (2) begin
      @(posedge clk);
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    req(4'h1, 16'h0000, 1'b1, 1'b0);
    req(4'h2, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0002, "external ticks");
    done("count");
    req(4'h2, 16'h1234, 1'b1, 1'b1);
    req(4'h1, 16'h4040, 1'b1, 1'b0);
    trig(1'b0, 1'b1);
    req(4'h6, 16'h0000, 1'b0, 1'b0);
    chk({8'h00, stat[23:16]} & 16'h0020, 16'h0020, "flag");
    req(4'h4, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h1234, "capture");
    req(4'h7, 16'h0000, 1'b1, 1'b0);
    chk({15'h0000, stat[2]}, 16'h0000, "masked");
    req(4'h7, 16'h2121, 1'b1, 1'b0);
    chk({15'h0000, stat[2]}, 16'h0001, "unmasked");
    req(4'h6, 16'h2020, 1'b1, 1'b0);
    chk({15'h0000, stat[2]}, 16'h0000, "one clears");
    req(4'h2, 16'h2222, 1'b1, 1'b1);
    trig(1'b0, 1'b0);
    stat_bit(2, 1'b0, "falling ignored");
    trig(1'b0, 1'b1);
    stat_bit(2, 1'b1, "second capture");
    req(4'h4, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h2222, "overwrite");
    trig(1'b0, 1'b0);
    req(4'h6, 16'h2020, 1'b1, 1'b0);
    done("capture");
    req(4'h1, 16'hC0C0, 1'b1, 1'b0);
    @(posedge clk);
    cap_pin <= 1'b1;
    repeat (2) @(posedge clk);
    cap_pin <= 1'b0;
    repeat (12) @(posedge clk);
    stat_bit(2, 1'b0, "glitch");
    trig(1'b0, 1'b1);
    stat_bit(2, 1'b1, "filtered edge");
    trig(1'b0, 1'b0);
    req(4'h6, 16'h2020, 1'b1, 1'b0);
    done("filter");
    // comparator high while the pin is low: the switch itself captures
    req(4'h2, 16'h0ABC, 1'b1, 1'b1);
    trig(1'b1, 1'b1);
    req(4'h8, 16'h0404, 1'b1, 1'b0);
    repeat (12) @(posedge clk);
    stat_bit(2, 1'b1, "switch captures");
    apb(`TC_P_ACK, 1'b1, 32'h00000004);
    stat_bit(2, 1'b0, "switch cleared");
    trig(1'b1, 1'b0);
    trig(1'b1, 1'b1);
    stat_bit(2, 1'b1, "comparator edge");
    req(4'h4, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0ABC, "comparator capture");
    done("source");
    req(4'h0, 16'h0202, 1'b1, 1'b0);
    req(4'h1, 16'h1818, 1'b1, 1'b0);
    req(4'h4, 16'h0300, 1'b1, 1'b1);
    req(4'h4, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0300, "capture top");
    req(4'h6, 16'h2020, 1'b1, 1'b0);
    req(4'h2, 16'h0300, 1'b1, 1'b1);
    chk({15'h0000, at_top}, 16'h0001, "top");
    trig(1'b1, 1'b0);
    stat_bit(2, 1'b0, "capture off");
    req(4'h0, 16'h0000, 1'b1, 1'b0);
    req(4'h1, 16'h0000, 1'b1, 1'b0);
    req(4'h4, 16'h5555, 1'b1, 1'b1);
    req(4'h4, 16'h0000, 1'b0, 1'b1);
    chk(stat[31:16], 16'h0300, "write refused");
    req(4'h5, 16'h5A5A, 1'b1, 1'b0);
    req(4'h3, 16'h0000, 1'b0, 1'b0);
    chk({8'h00, stat[23:16]}, 16'h005A, "shared latch");
    done("modes");
    conclude();
  end
endmodule
